// [include/ifa_consts.svh]
// Notes on behaviour
// - Output A fault: one pulse, off after 30 min.
// - Output B fault: two pulses, off after 30 min.
// - Cross short or both: three pulses, delayed off.
// - Overtemperature: four pulses, delayed off.
// - Actuator fault: five pulses, outputs off at once.
// - Control input error: six pulses, no shutdown.
// - Detection lost: seven pulses, outputs off at once.
// - Drive blocked: eight pulses, outputs off at once.
// - Supply out of range: nine pulses, immediate off.
// - Warning held 30 min enters error state.
// - Inputs toggling too fast: yellow 2 Hz, off.
// - Warning clears itself once its cause goes.
// - Latched error clears on guard open or power, an internal defect on power only.
`ifndef IFA_CONSTS_SVH
`define IFA_CONSTS_SVH

// System clock rate in hertz.
`define IFA_CLK_HZ 10000000
// Delay from warning to autonomous switch-off, in minutes.
`define IFA_WARN_MIN 30
// Highest allowed toggle rate of a command input, in millihertz.
`define IFA_CMD_MAX_MHZ 300
// Yellow fault flash rate, in hertz.
`define IFA_YEL_HZ 2
// Red code timing, in milliseconds.
`define IFA_RED_ON_MS 250
`define IFA_RED_GAP_MS 250
`define IFA_RED_PAUSE_MS 1500

// Derived cycle counts, computed in 64 bits to avoid overflow.
`define IFA_WARN_CYC (64'd60 * `IFA_WARN_MIN * `IFA_CLK_HZ)
`define IFA_CMD_GAP_CYC (64'd1000 * `IFA_CLK_HZ / (64'd2 * `IFA_CMD_MAX_MHZ))
`define IFA_YEL_HALF_CYC (64'd1 * `IFA_CLK_HZ / (64'd2 * `IFA_YEL_HZ))
`define IFA_RED_ON_CYC (64'd1 * `IFA_RED_ON_MS * `IFA_CLK_HZ / 64'd1000)
`define IFA_RED_GAP_CYC (64'd1 * `IFA_RED_GAP_MS * `IFA_CLK_HZ / 64'd1000)
`define IFA_RED_PAUSE_CYC (64'd1 * `IFA_RED_PAUSE_MS * `IFA_CLK_HZ / 64'd1000)

// Counter widths.
`define IFA_WARN_W 36
`define IFA_TMR_W 32
`define IFA_TMR_SAT 32'hFFFFFFFF

// Red pulse-count codes.
`define IFA_CODE_NONE 4'h0
`define IFA_CODE_OUT_A 4'h1
`define IFA_CODE_OUT_B 4'h2
`define IFA_CODE_CROSS 4'h3
`define IFA_CODE_TEMP 4'h4
`define IFA_CODE_ACT 4'h5
`define IFA_CODE_CTRL 4'h6
`define IFA_CODE_DETECT 4'h7
`define IFA_CODE_DRIVE 4'h8
`define IFA_CODE_SUPPLY 4'h9

`endif

// [include/ifa_pkg.sv]
package ifa_pkg;

	// Phases of the red pulse-count sequencer.
	typedef enum logic [1:0]
	{
		IFA_PH_IDLE = 2'b00,
		IFA_PH_ON = 2'b01,
		IFA_PH_GAP = 2'b10,
		IFA_PH_PAUSE = 2'b11
	} ifa_phase_t;

	// Whole state of the red pulse-count sequencer.
	typedef struct packed
	{
		ifa_phase_t phase;
		logic [3:0] left;
		logic [31:0] tmr;
		logic led;
	} ifa_blink_st_t;

	// Whole state of the annunciator core.
	typedef struct packed
	{
		logic err;
		logic [3:0] code;
		logic internal;
		logic cmd_fast;
		logic [35:0] warn_tmr;
		logic [31:0] gap_a;
		logic [31:0] gap_b;
		logic cmd_a;
		logic cmd_b;
		logic [31:0] yel_tmr;
		logic yel_phase;
		logic safe_a;
		logic safe_b;
		logic yel_led;
		logic warn;
	} ifa_core_st_t;

endpackage

// [include/ifa_code_if.sv]
`timescale 1ns/1ps
// Carries the code to show on the red LED and the LED drive back.
interface ifa_code_if;
	logic [3:0] code;
	logic solid;
	logic led;

	// The core chooses what to show.
	modport src
	(
		output code,
		output solid,
		input led
	);

	// The sequencer turns it into pulses.
	modport sink
	(
		input code,
		input solid,
		output led
	);
endinterface

// [hdl/ifa_blinker.sv]
`timescale 1ns/1ps
`include "ifa_consts.svh"
// Turns a code number into groups of red pulses.
module ifa_blinker
	import ifa_pkg::*;
#(
	parameter logic [31:0] ON_CYC = 32'(`IFA_RED_ON_CYC),
	parameter logic [31:0] GAP_CYC = 32'(`IFA_RED_GAP_CYC),
	parameter logic [31:0] PAUSE_CYC = 32'(`IFA_RED_PAUSE_CYC)
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Code in, LED out.
	ifa_code_if.sink cif
);

	ifa_blink_st_t st_q; // Registered state.
	ifa_blink_st_t st_d; // Next state.

	// The code is taken only at the start of a group, so a change
	// never leaves a half-counted group that would mislead a viewer.
	always_comb
	begin
		st_d = st_q;
		unique case (st_q.phase)
			IFA_PH_IDLE:
			begin
				// Start a new group whenever there is something to show.
				if (cif.code != `IFA_CODE_NONE)
				begin
					st_d.phase = IFA_PH_ON;
					st_d.left = cif.code;
					st_d.tmr = ON_CYC - 32'h00000001;
				end
			end
			IFA_PH_ON:
			begin
				if (st_q.tmr == 32'h00000000)
				begin
					st_d.left = st_q.left - 4'h1;
					// The last pulse is followed by the long pause.
					if (st_q.left == 4'h1)
					begin
						st_d.phase = IFA_PH_PAUSE;
						st_d.tmr = PAUSE_CYC - 32'h00000001;
					end
					else
					begin
						st_d.phase = IFA_PH_GAP;
						st_d.tmr = GAP_CYC - 32'h00000001;
					end
				end
				else
				begin
					st_d.tmr = st_q.tmr - 32'h00000001;
				end
			end
			IFA_PH_GAP:
			begin
				// Short dark gap between pulses of one group.
				if (st_q.tmr == 32'h00000000)
				begin
					st_d.phase = IFA_PH_ON;
					st_d.tmr = ON_CYC - 32'h00000001;
				end
				else
				begin
					st_d.tmr = st_q.tmr - 32'h00000001;
				end
			end
			IFA_PH_PAUSE:
			begin
				// Long dark pause before the group repeats.
				if (st_q.tmr == 32'h00000000)
				begin
					st_d.phase = IFA_PH_IDLE;
				end
				else
				begin
					st_d.tmr = st_q.tmr - 32'h00000001;
				end
			end
		endcase
		// A defect overrides pulsing with a steady light.
		st_d.led = cif.solid | (st_d.phase == IFA_PH_ON);
	end

	// State register.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign cif.led = st_q.led;

endmodule

// [hdl/ifa_top.sv]
`timescale 1ns/1ps
`include "ifa_consts.svh"
// Fault annunciator and timed shutdown for a guard interlock.
module ifa_top
	import ifa_pkg::*;
#(
	parameter logic [35:0] WARN_CYC = 36'(`IFA_WARN_CYC),
	parameter logic [31:0] CMD_GAP_CYC = 32'(`IFA_CMD_GAP_CYC),
	parameter logic [31:0] YEL_HALF_CYC = 32'(`IFA_YEL_HALF_CYC),
	parameter logic [31:0] RED_ON_CYC = 32'(`IFA_RED_ON_CYC),
	parameter logic [31:0] RED_GAP_CYC = 32'(`IFA_RED_GAP_CYC),
	parameter logic [31:0] RED_PAUSE_CYC = 32'(`IFA_RED_PAUSE_CYC)
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Fault detectors, each a level that is high while detected.
	input wire logic flt_out_a,
	input wire logic flt_out_b,
	input wire logic flt_cross,
	input wire logic flt_temp,
	input wire logic flt_actuator,
	input wire logic flt_ctrl,
	input wire logic flt_detect,
	input wire logic flt_drive,
	input wire logic flt_supply,
	input wire logic flt_internal,
	// Control inputs from the controller.
	input wire logic lock_cmd_in_a,
	input wire logic lock_cmd_in_b,
	// Guard and locking condition.
	input wire logic guard_open,
	input wire logic lock_ok,
	input wire logic yellow_status,
	// Safety outputs.
	output logic safety_out_a,
	output logic safety_out_b,
	// Indicators.
	output logic led_red,
	output logic led_yellow,
	output logic warn_active,
	output logic error_latched
);

	ifa_core_st_t st_q; // Registered state.
	ifa_core_st_t st_d; // Next state.
	ifa_code_if cif(); // Link to the pulse sequencer.

	// Decoded view of the present faults.
	logic warn_any; // A fault that only delays shutdown is present.
	logic imm_any; // A fault that demands shutdown at once is present.
	logic [3:0] warn_code; // Code of the most serious present warning.
	logic [3:0] imm_code; // Code of the first present immediate fault.
	logic edge_a; // Command input A changed this cycle.
	logic edge_b; // Command input B changed this cycle.
	logic fast_now; // A command input toggled too soon after the last.
	logic warn_expired; // The warning has run its full period.
	logic trip; // Something switches the outputs off this cycle.
	logic clear_ok; // The latched error may be released this cycle.
	logic [3:0] disp_code; // Code that the red LED should count out.

	// Classify the warning faults. A fault on both outputs reads as a
	// cross short, since the two cannot be told apart from outside.
	always_comb
	begin
		warn_any = flt_out_a | flt_out_b | flt_cross | flt_temp;
		if (flt_cross | (flt_out_a & flt_out_b))
		begin
			warn_code = `IFA_CODE_CROSS;
		end
		else if (flt_out_a)
		begin
			warn_code = `IFA_CODE_OUT_A;
		end
		else if (flt_out_b)
		begin
			warn_code = `IFA_CODE_OUT_B;
		end
		else if (flt_temp)
		begin
			warn_code = `IFA_CODE_TEMP;
		end
		else
		begin
			warn_code = `IFA_CODE_NONE;
		end
	end

	// Classify the faults that switch off at once. The lowest code wins
	// when several are present, the others show after it is gone.
	always_comb
	begin
		imm_any = flt_actuator | flt_detect | flt_drive | flt_supply;
		if (flt_actuator)
		begin
			imm_code = `IFA_CODE_ACT;
		end
		else if (flt_detect)
		begin
			imm_code = `IFA_CODE_DETECT;
		end
		else if (flt_drive)
		begin
			imm_code = `IFA_CODE_DRIVE;
		end
		else if (flt_supply)
		begin
			imm_code = `IFA_CODE_SUPPLY;
		end
		else
		begin
			imm_code = `IFA_CODE_NONE;
		end
	end

	// Edge spacing check on the command inputs. Two edges closer than
	// half the shortest allowed period mean the rate is too high.
	always_comb
	begin
		edge_a = lock_cmd_in_a ^ st_q.cmd_a;
		edge_b = lock_cmd_in_b ^ st_q.cmd_b;
		fast_now = (edge_a & (st_q.gap_a < CMD_GAP_CYC))
			| (edge_b & (st_q.gap_b < CMD_GAP_CYC));
	end

	// Shutdown and release conditions.
	always_comb
	begin
		// The timer holds how many cycles the warning has been seen, so
		// the trip lands once the warning has stood the whole period.
		warn_expired = warn_any
			& (st_q.warn_tmr >= WARN_CYC);
		// The control input error is left out on purpose: it only shows.
		trip = imm_any | fast_now | flt_internal | warn_expired;
		// Release needs the cause gone and the guard opened; a defect is
		// kept until power is cycled, since the part can't be trusted.
		clear_ok = guard_open & ~imm_any & ~warn_any & ~st_q.internal;
	end

	// Code for the red LED: a latched error shows its cause, otherwise
	// a live warning, otherwise a control input error.
	always_comb
	begin
		if (st_q.err & (st_q.code != `IFA_CODE_NONE))
		begin
			disp_code = st_q.code;
		end
		else if (warn_any)
		begin
			disp_code = warn_code;
		end
		else if (flt_ctrl)
		begin
			disp_code = `IFA_CODE_CTRL;
		end
		else
		begin
			disp_code = `IFA_CODE_NONE;
		end
	end

	assign cif.code = disp_code;
	assign cif.solid = st_q.internal | flt_internal;

	// Next state of the whole core.
	always_comb
	begin
		st_d = st_q;
		st_d.cmd_a = lock_cmd_in_a;
		st_d.cmd_b = lock_cmd_in_b;
		// Gap counters restart at one on each edge, so at the next edge
		// they hold its distance in cycles; they stop at saturation.
		if (edge_a)
		begin
			st_d.gap_a = 32'h00000001;
		end
		else if (st_q.gap_a != `IFA_TMR_SAT)
		begin
			st_d.gap_a = st_q.gap_a + 32'h00000001;
		end
		if (edge_b)
		begin
			st_d.gap_b = 32'h00000001;
		end
		else if (st_q.gap_b != `IFA_TMR_SAT)
		begin
			st_d.gap_b = st_q.gap_b + 32'h00000001;
		end
		// The warning timer runs only while a warning is present and
		// drops back to zero as soon as the cause is gone.
		if (warn_any & ~st_q.err)
		begin
			if (st_q.warn_tmr < WARN_CYC)
			begin
				st_d.warn_tmr = st_q.warn_tmr + 36'h000000001;
			end
		end
		else
		begin
			st_d.warn_tmr = '0;
		end
		// Latch or release the error. A new cause in the release cycle
		// keeps the error, so no fault slips through a release.
		if (trip)
		begin
			st_d.err = 1'b1;
			if (flt_internal)
			begin
				st_d.internal = 1'b1;
			end
			if (fast_now)
			begin
				st_d.cmd_fast = 1'b1;
			end
			if (imm_any)
			begin
				st_d.code = imm_code;
			end
			else if (warn_expired)
			begin
				st_d.code = warn_code;
			end
		end
		else if (st_q.err & clear_ok)
		begin
			st_d.err = 1'b0;
			st_d.code = `IFA_CODE_NONE;
			st_d.cmd_fast = 1'b0;
		end
		// Yellow flash timer toggles the phase every half period.
		if (st_q.yel_tmr == 32'h00000000)
		begin
			st_d.yel_tmr = YEL_HALF_CYC - 32'h00000001;
			st_d.yel_phase = ~st_q.yel_phase;
		end
		else
		begin
			st_d.yel_tmr = st_q.yel_tmr - 32'h00000001;
		end
		// Safety outputs follow the lock only while no error is latched
		// or tripping; they fall at the same edge that latches the error.
		st_d.safe_a = lock_ok & ~st_d.err;
		st_d.safe_b = lock_ok & ~st_d.err;
		// Fast command toggling takes the yellow LED over.
		st_d.yel_led = st_d.cmd_fast ? st_d.yel_phase : yellow_status;
		// Warning flag for the controller to stop the process softly.
		st_d.warn = warn_any & ~st_d.err;
	end

	// State register.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= '0;
			// Gaps start saturated so the first edge is never too fast.
			st_q.gap_a <= `IFA_TMR_SAT;
			st_q.gap_b <= `IFA_TMR_SAT;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// Red pulse sequencer.
	ifa_blinker #(
		.ON_CYC(RED_ON_CYC),
		.GAP_CYC(RED_GAP_CYC),
		.PAUSE_CYC(RED_PAUSE_CYC)
	) u_blink (
		.clk(clk),
		.rst(rst),
		.cif(cif)
	);

	// Outputs, all from flip-flops.
	assign safety_out_a = st_q.safe_a;
	assign safety_out_b = st_q.safe_b;
	assign led_red = cif.led;
	assign led_yellow = st_q.yel_led;
	assign warn_active = st_q.warn;
	assign error_latched = st_q.err;

endmodule

// [testbench/ifa_assertions.sv]
`timescale 1ns/1ps
// Port checks of trip timing, output gating and red code shape.
module ifa_assertions
	import ifa_pkg::*;
#(
	parameter logic [35:0] WARN_CYC = 36'h64,
	parameter logic [31:0] CMD_GAP_CYC = 32'h14
)
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Fault levels.
	input wire logic flt_out_a,
	input wire logic flt_out_b,
	input wire logic flt_cross,
	input wire logic flt_temp,
	input wire logic flt_actuator,
	input wire logic flt_detect,
	input wire logic flt_drive,
	input wire logic flt_supply,
	input wire logic flt_internal,
	// Commands and guard.
	input wire logic lock_cmd_in_a,
	input wire logic lock_cmd_in_b,
	input wire logic guard_open,
	input wire logic lock_ok,
	// Outputs watched.
	input wire logic safety_out_a,
	input wire logic safety_out_b,
	input wire logic led_red,
	input wire logic warn_active,
	input wire logic error_latched
);
	// Cycles since the last edge on command A, saturating.
	logic [31:0] gap_q;
	// Consecutive cycles with a warning shown.
	logic [35:0] wcnt_q;
	// Last command levels.
	logic [1:0] cmd_q;
	// Sticky defect flag; only reset clears it, as in the design.
	logic int_q;
	wire logic imm = flt_actuator | flt_detect | flt_drive | flt_supply;
	wire logic wrn = flt_out_a | flt_out_b | flt_cross | flt_temp;
	wire logic still = ({lock_cmd_in_a, lock_cmd_in_b} == cmd_q);

	// Helper state for the timing checks.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			gap_q <= '1;
			wcnt_q <= '0;
			cmd_q <= '0;
			int_q <= 1'b0;
		end
		else
		begin
			gap_q <= (lock_cmd_in_a != cmd_q[1]) ? 32'h1 :
				((gap_q == '1) ? gap_q : gap_q + 32'h1);
			wcnt_q <= warn_active ? wcnt_q + 36'h1 : '0;
			cmd_q <= {lock_cmd_in_a, lock_cmd_in_b};
			int_q <= int_q | flt_internal;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_imm_trip:
	assert property (imm |=> error_latched && !safety_out_a)
		else $error("immediate fault did not trip");
	a_out_gate:
	assert property (safety_out_a |-> safety_out_b && !error_latched
		&& $past(lock_ok)) else $error("safety outputs badly gated");
	a_cmd_fast:
	assert property ((lock_cmd_in_a != cmd_q[1] && gap_q < CMD_GAP_CYC)
		|=> error_latched) else $error("fast command edge missed");
	a_no_cause:
	assert property ((!error_latched && !imm && !wrn && !flt_internal
		&& still) |=> !error_latched) else $error("trip without cause");
	a_guard_clear:
	assert property ((error_latched && guard_open && !int_q && !imm
		&& !wrn && !flt_internal && still) |=> !error_latched)
		else $error("guard open did not clear error");
	a_red_on_len:
	assert property ($rose(led_red) && !int_q |-> led_red[*3] ##1
		!led_red) else $error("red pulse length wrong");
	a_red_off_len:
	assert property ($fell(led_red) && !int_q |-> !led_red[*3])
		else $error("red gap too short");
	a_int_solid:
	assert property (flt_internal |=> error_latched ##1 led_red)
		else $error("internal defect not shown");
	a_warn_bound:
	assert property (wcnt_q <= WARN_CYC)
		else $error("warning outlived its delay");
endmodule

bind ifa_top ifa_assertions #(.WARN_CYC(WARN_CYC),
	.CMD_GAP_CYC(CMD_GAP_CYC)) u_chk (.clk(clk), .rst(rst),
	.flt_out_a(flt_out_a), .flt_out_b(flt_out_b), .flt_cross(flt_cross),
	.flt_temp(flt_temp), .flt_actuator(flt_actuator),
	.flt_detect(flt_detect), .flt_drive(flt_drive),
	.flt_supply(flt_supply), .flt_internal(flt_internal),
	.lock_cmd_in_a(lock_cmd_in_a), .lock_cmd_in_b(lock_cmd_in_b),
	.guard_open(guard_open), .lock_ok(lock_ok),
	.safety_out_a(safety_out_a), .safety_out_b(safety_out_b),
	.led_red(led_red), .warn_active(warn_active),
	.error_latched(error_latched));

// [testbench/ifa_ctrl_model.sv]
`timescale 1ns/1ps
// Controller side: toggles both command inputs together every gap
// cycles while go is high, and holds them still otherwise.
module ifa_ctrl_model
(
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Toggle spacing in cycles, and enable.
	input wire logic [31:0] gap,
	input wire logic go,
	// Command levels.
	output logic cmd_a,
	output logic cmd_b
);
	// Cycles since the last toggle.
	logic [31:0] cnt_q;

	// Spacing is exact, so the bench can sit on the limit itself.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_q <= '0;
			cmd_a <= 1'b0;
		end
		else if (go && cnt_q >= gap - 32'h1)
		begin
			cnt_q <= '0;
			cmd_a <= ~cmd_a;
		end
		else
			cnt_q <= cnt_q + 32'h1;
	end
	// Both channels move as one, as a two-channel controller does.
	assign cmd_b = cmd_a;
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
// Self-checking bench: drivers queue expectations, a monitor compares.
module tb;
	import ifa_pkg::*;
	localparam int WC = 100;
	// One expected output level at a monitor cycle.
	typedef struct {int c; int s; logic v;} ifa_exp_t;
	ifa_exp_t q[$];
	string nm[6] = '{"safety_out_a", "safety_out_b", "led_red",
		"led_yellow", "warn_active", "error_latched"};
	int im[4] = '{4, 6, 7, 8};
	int ic[4] = '{5, 7, 8, 9};
	logic [9:0] wm[5] = '{10'h1, 10'h2, 10'h3, 10'h4, 10'h8};
	int wc[5] = '{1, 2, 3, 3, 4};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [9:0] f = '0; // One bit per fault detector.
	logic go = 1'b0;
	logic guard = 1'b0;
	logic lok = 1'b0;
	logic ys = 1'b0;
	logic b;
	logic [31:0] gap = 32'h14;
	int cyc = 0;
	int error_cnt = 0;
	int cmp_count = 0;
	int r;
	int n;
	wire logic ca;
	wire logic cb;
	wire logic [5:0] o; // Outputs, in the order of nm.

	initial forever #50 clk = ~clk;

	ifa_top #(.WARN_CYC(36'h64), .CMD_GAP_CYC(32'h14),
		.YEL_HALF_CYC(32'h4), .RED_ON_CYC(32'h3), .RED_GAP_CYC(32'h3),
		.RED_PAUSE_CYC(32'hA)) dut (.clk(clk), .rst(rst),
		.flt_out_a(f[0]), .flt_out_b(f[1]), .flt_cross(f[2]),
		.flt_temp(f[3]), .flt_actuator(f[4]), .flt_ctrl(f[5]),
		.flt_detect(f[6]), .flt_drive(f[7]), .flt_supply(f[8]),
		.flt_internal(f[9]), .lock_cmd_in_a(ca), .lock_cmd_in_b(cb),
		.guard_open(guard), .lock_ok(lok), .yellow_status(ys),
		.safety_out_a(o[0]), .safety_out_b(o[1]), .led_red(o[2]),
		.led_yellow(o[3]), .warn_active(o[4]), .error_latched(o[5]));

	ifa_ctrl_model m (.clk(clk), .rst(rst), .gap(gap), .go(go),
		.cmd_a(ca), .cmd_b(cb));

	task automatic chk(input int s, input logic e, input logic g);
		cmp_count++;
		if (g !== e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %b seen %b", nm[s], e, g);
		end
	endtask

	task automatic chkn(input string s, input int e, input int g);
		cmp_count++;
		if (g != e)
		begin
			error_cnt++;
			$display("CHECK FAILED %s expected %0d seen %0d", s, e, g);
		end
	endtask

	// Monitor: outputs are settled at the falling edge.
	always @(negedge clk)
	begin
		cyc = cyc + 1;
		while (q.size() > 0 && q[0].c <= cyc)
		begin
			chk(q[0].s, q[0].v, o[q[0].s]);
			void'(q.pop_front());
		end
	end

	// Delay d counts monitor cycles; 2 is the first registered answer.
	task automatic ex(input int s, input logic v, input int d);
		q.push_back('{cyc + d, s, v});
	endtask

	task automatic tk(input int k);
		repeat (k) @(posedge clk);
	endtask

	// One full red group of k pulses plus the start of the next. The
	// first pulse comes o cycles on: 2 for a code shown from a live
	// fault, 3 for one that waits for the error to latch.
	task automatic code(input int k, input int o);
		for (int t = 0; t <= 6 * k + 8; t++)
			ex(2, (t < 6 * k - 3 && t % 6 < 3) || t == 6 * k + 8, t + o);
	endtask

	task automatic do_rst;
		rst <= 1'b1;
		tk(10);
		rst <= 1'b0;
	endtask

	// Cause gone, guard opened once; then let the red group run out.
	task automatic clr;
		f <= '0;
		guard <= 1'b1;
		ex(5, 1'b0, 2);
		ex(0, 1'b1, 2);
		tk(1);
		guard <= 1'b0;
		tk(70);
	endtask

	task automatic wrap_up;
		$display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial
	begin
		r = $urandom(31848);
		do_rst();
		lok <= 1'b1;
		tk(3);
		ex(0, 1'b1, 1);
		foreach (im[i])
		begin
			f[im[i]] <= 1'b1;
			ex(5, 1'b1, 2);
			ex(0, 1'b0, 2);
			code(ic[i], 3);
			tk(70);
			clr();
		end
		foreach (wm[i])
		begin
			f <= wm[i];
			ex(4, 1'b1, 2);
			ex(0, 1'b1, 2);
			code(wc[i], 2);
			ex(5, 1'b0, WC + 1);
			ex(5, 1'b1, WC + 2);
			ex(0, 1'b0, WC + 2);
			tk(WC + 10);
			clr();
		end
		f <= 10'h8;
		tk(10);
		f <= '0;
		ex(4, 1'b0, 2);
		ex(5, 1'b0, 2);
		tk(70);
		f <= 10'h20;
		ex(0, 1'b1, 2);
		code(6, 2);
		ex(5, 1'b0, WC + 2);
		tk(WC + 10);
		// Outputs must still follow the lock while the input error shows.
		repeat (8)
		begin
			@(posedge clk);
			b = 1'($urandom);
			lok <= b;
			ex(0, b, 2);
			ex(1, b, 2);
		end
		@(posedge clk);
		lok <= 1'b1;
		ex(1, 1'b1, 2);
		f <= '0;
		tk(70);
		go <= 1'b1;
		repeat (100)
		begin
			@(posedge clk);
			b = 1'($urandom);
			ys <= b;
			ex(3, b, 2);
		end
		ex(5, 1'b0, 3);
		tk(1);
		gap <= 32'h13;
		tk(45);
		ex(5, 1'b1, 1);
		ex(0, 1'b0, 1);
		@(negedge clk);
		n = 0;
		repeat (40)
		begin
			b = o[3];
			@(negedge clk);
			n += int'(o[3] !== b);
		end
		chkn("led_yellow toggles", 10, n);
		@(posedge clk);
		go <= 1'b0;
		tk(30);
		clr();
		f <= 10'h200;
		tk(1);
		f <= '0;
		guard <= 1'b1;
		ex(5, 1'b1, 1);
		ex(0, 1'b0, 1);
		for (int t = 2; t <= 40; t++)
			ex(2, 1'b1, t);
		ex(5, 1'b1, 40);
		tk(42);
		guard <= 1'b0;
		do_rst();
		tk(3);
		ex(5, 1'b0, 1);
		ex(0, 1'b1, 1);
		ex(1, 1'b1, 1);
		ex(2, 1'b0, 1);
		tk(5);
		wrap_up();
	end

	// Whole run is about 2100 cycles; this cuts a hang short.
	initial
	begin
		#1000000;
		error_cnt++;
		wrap_up();
	end
endmodule
